// file: ssq_startup_seq.sv
/*
  Startup reset sequencer top: power-on reset timer, global reset combine,
  synchronous release, clock request, minimum sleep and clock source choice.
  Assumes nrst_i is the core supply good level and all pins are synchronous.
*/
// Operation
// - Held external reset blocks startup and boot
// - Without external reset, start after power-on reset
// - Global reset active while either source active
// - Latest released source sets the release moment
// - Power-on reset lasts typically 3 ms
// - One common sequence after any reset
// - Raise clock request 120 us after release
// - Stay asleep at least 4.2 ms
// - No fitted reference module means crystal used
// - No slow clock seen selects internal one
`timescale 1ns/1ps
module ssq_startup_seq
#(
  parameter int unsigned POR_CYCLES    = ssq_pkg::POR_TYP_CYC,
  parameter int unsigned CLKREQ_CYCLES = ssq_pkg::CLKREQ_CYC,
  parameter int unsigned SLEEP_CYCLES  = ssq_pkg::SLEEP_MIN_CYC
)
(
  // Clock and core supply reset
  input  wire logic ref_clk_i,
  input  wire logic nrst_i,
  // External reset pin
  input  wire logic ext_rst_n_i,
  // Board straps and slow clock
  input  wire logic temp_comp_ref_oscillator_i,
  input  wire logic slow_clock_input_i,
  // Reset status
  output logic      por_active_o,
  output logic      chip_rst_n_o,
  // Sequence outputs
  output logic      clk_req_o,
  output logic      sleep_o,
  output logic      boot_go_o,
  // Clock source selection
  output logic      crystal_osc_en_o,
  output logic      ref_from_module_o,
  output logic      low_power_oscillator_ext_o
);
  import ssq_pkg::*;

  localparam logic [CNT_W-1:0] POR_LAST    = CNT_W'(POR_CYCLES - 1);
  localparam logic [CNT_W-1:0] CLKREQ_LAST = CNT_W'(CLKREQ_CYCLES - 1);
  localparam logic [CNT_W-1:0] SLEEP_LAST  = CNT_W'(SLEEP_CYCLES - 1);

  // Power-on reset timer, runs from core supply good
  logic [CNT_W-1:0] por_cnt_q;
  logic [CNT_W-1:0] por_cnt_d;
  logic             por_done_q;
  logic             por_done_d;

  // Combined reset and its synchronised release
  logic             comb_rst_n;
  logic             seq_rst_n;

  // Post-release sequence
  ssq_state_e       state_q;
  ssq_state_e       state_d;
  logic [CNT_W-1:0] seq_cnt_q;
  logic [CNT_W-1:0] seq_cnt_d;
  logic             clk_req_q;
  logic             clk_req_d;
  logic             done_q;
  logic             done_d;
  logic             strap_taken_q;
  logic             strap_taken_d;
  logic             ref_mod_q;
  logic             ref_mod_d;
  logic             slow_ext_q;
  logic             slow_ext_d;
  logic             slow_present;

  // hold power-on reset for the configured time
  always_comb
  begin
    por_cnt_d  = por_cnt_q;
    por_done_d = por_done_q;
    if (!por_done_q)
    begin
      if (por_cnt_q == POR_LAST)
      begin
        por_done_d = 1'b1;
      end
      else
      begin
        por_cnt_d = por_cnt_q + 18'h00001;
      end
    end
  end

  // internal timer alone can release the chip
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      por_cnt_q  <= CNT_RST;
      por_done_q <= 1'b0;
    end
    else
    begin
      por_cnt_q  <= por_cnt_d;
      por_done_q <= por_done_d;
    end
  end

  // wired-AND of both active-low reset sources
  // last source freed ends the reset
  assign comb_rst_n = nrst_i & ext_rst_n_i & por_done_q;

  // release of the combined reset waits for two clock edges
  ssq_rst_sync u_rst_sync
  (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (comb_rst_n),
    .rst_n_o   (seq_rst_n)
  );

  ssq_slow_det u_slow_det
  (
    .ref_clk_i          (ref_clk_i),
    .rst_n_i            (seq_rst_n),
    .slow_clock_input_i (slow_clock_input_i),
    .present_o          (slow_present)
  );

  // same sequence whichever source released last
  always_comb
  begin
    state_d       = state_q;
    seq_cnt_d     = seq_cnt_q;
    clk_req_d     = clk_req_q;
    done_d        = done_q;
    strap_taken_d = 1'b1;
    ref_mod_d     = ref_mod_q;
    slow_ext_d    = slow_ext_q;
    if (!strap_taken_q)
    begin
      ref_mod_d = temp_comp_ref_oscillator_i;
    end
    case (state_q)
      SEQ_SLEEP:
      begin
        seq_cnt_d = seq_cnt_q + 18'h00001;
        if (seq_cnt_q == CLKREQ_LAST)
        begin
          clk_req_d = 1'b1;
        end
        // leave sleep only after the minimum time
        if (seq_cnt_q == SLEEP_LAST)
        begin
          state_d = SEQ_RUN;
          done_d  = 1'b1;
          // host clocks are expected running by now
          // choose external slow clock only if seen
          slow_ext_d = slow_present;
        end
      end
      SEQ_RUN:
      begin
        seq_cnt_d = seq_cnt_q;
      end
      default:
      begin
        state_d = SEQ_SLEEP;
      end
    endcase
  end

  // sequence state held in reset while pin asserted
  always_ff @(posedge ref_clk_i or negedge seq_rst_n)
  begin
    if (!seq_rst_n)
    begin
      state_q       <= SEQ_SLEEP;
      seq_cnt_q     <= CNT_RST;
      clk_req_q     <= CLK_REQ_RST;
      done_q        <= DONE_RST;
      strap_taken_q <= 1'b0;
      ref_mod_q     <= REF_MOD_SEL_RST;
      slow_ext_q    <= SLOW_EXT_SEL_RST;
    end
    else
    begin
      state_q       <= state_d;
      seq_cnt_q     <= seq_cnt_d;
      clk_req_q     <= clk_req_d;
      done_q        <= done_d;
      strap_taken_q <= strap_taken_d;
      ref_mod_q     <= ref_mod_d;
      slow_ext_q    <= slow_ext_d;
    end
  end

  // Outputs; crystal oscillator is on by default since no strap is known yet
  assign por_active_o               = !por_done_q;
  assign chip_rst_n_o               = seq_rst_n;
  assign clk_req_o                  = clk_req_q;
  assign sleep_o                    = seq_rst_n && state_q == SEQ_SLEEP;
  assign boot_go_o                  = done_q;
  assign ref_from_module_o          = ref_mod_q;
  // crystal drives the reference unless module fitted
  assign crystal_osc_en_o           = !ref_mod_q;
  assign low_power_oscillator_ext_o = slow_ext_q;

  // Pin held low keeps the boot and clock request off
  a_pin_blocks_boot: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !ext_rst_n_i |=> (!boot_go_o && !clk_req_o && !chip_rst_n_o))
    else $error("startup progressed while reset pin held");

  // Nothing of the sequence shows while in reset
  a_idle_in_reset: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !chip_rst_n_o |-> (!sleep_o && !boot_go_o && !clk_req_o))
    else $error("sequence output active during reset");

  // Power-on timer releases after exactly the configured count
  a_por_release_time: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    $rose(por_done_q) |-> $past(por_cnt_q) == POR_LAST)
    else $error("power-on reset released at wrong count");

  // Timer steps by one per edge and never finishes early
  a_por_count_step: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (!por_done_q && por_cnt_q != POR_LAST) |=> (!por_done_q && por_cnt_q == $past(por_cnt_q) + 18'h00001))
    else $error("power-on timer skipped or ended early");

  // Power-on timer done with pin idle leads to release in two edges
  a_por_alone_starts: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (por_done_q && ext_rst_n_i) [*3] |-> chip_rst_n_o)
    else $error("chip not released after power-on reset");

  // Either source active forces global reset
  a_either_resets: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (!ext_rst_n_i || !por_done_q) |=> !chip_rst_n_o)
    else $error("global reset not active with a source active");

  // Release only after both sources were free for two edges
  a_release_latest: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    $rose(chip_rst_n_o) |-> ($past(comb_rst_n, 2) && $past(comb_rst_n)))
    else $error("released before the later source cleared");

  // Sequence always starts from the same point
  a_common_start: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    $rose(chip_rst_n_o) |-> (seq_cnt_q == CNT_RST && state_q == SEQ_SLEEP && !clk_req_o))
    else $error("sequence did not start from its common origin");

  // Clock request rises exactly at the delay
  a_clk_req_delay: assert property (@(posedge ref_clk_i) disable iff (!seq_rst_n)
    $rose(clk_req_o) |-> ($past(seq_cnt_q) == CLKREQ_LAST && sleep_o))
    else $error("clock request at wrong time");

  // Clock request stays up until a reset source acts
  a_clk_req_sticky: assert property (@(posedge ref_clk_i) disable iff (!seq_rst_n)
    clk_req_o |=> clk_req_o)
    else $error("clock request dropped without reset");

  // Boot never comes before the clock request
  a_boot_after_req: assert property (@(posedge ref_clk_i) disable iff (!seq_rst_n)
    boot_go_o |-> clk_req_o)
    else $error("boot without clock request");

  // Boot only after the full sleep time
  a_sleep_minimum: assert property (@(posedge ref_clk_i) disable iff (!seq_rst_n)
    $rose(boot_go_o) |-> ($past(seq_cnt_q) == SLEEP_LAST && $past(sleep_o) && !sleep_o))
    else $error("sleep left early or late");

  // No boot while the sleep count is short of its end
  a_sleep_no_boot: assert property (@(posedge ref_clk_i) disable iff (!seq_rst_n)
    (sleep_o && seq_cnt_q != SLEEP_LAST) |=> !boot_go_o)
    else $error("boot before sleep count ended");

  // Once booted the chip stays awake
  a_boot_sticky: assert property (@(posedge ref_clk_i) disable iff (!seq_rst_n)
    boot_go_o |=> (boot_go_o && !sleep_o))
    else $error("boot dropped or sleep resumed");

  // Reference choice matches the strap seen at capture
  a_ref_source: assert property (@(posedge ref_clk_i) disable iff (!seq_rst_n)
    $rose(strap_taken_q) |-> (ref_from_module_o == $past(temp_comp_ref_oscillator_i)
                              && crystal_osc_en_o == !ref_from_module_o))
    else $error("reference source choice wrong");

  // Reference choice frozen after capture
  a_strap_frozen: assert property (@(posedge ref_clk_i) disable iff (!seq_rst_n)
    strap_taken_q |=> $stable(ref_from_module_o))
    else $error("reference source changed after capture");

  // Crystal and internal slow clock are the reset choices
  a_crystal_in_reset: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !chip_rst_n_o |-> (crystal_osc_en_o && !ref_from_module_o && !low_power_oscillator_ext_o))
    else $error("clock source choice wrong in reset");

  // Slow clock choice follows detector at sleep end
  a_slow_choice: assert property (@(posedge ref_clk_i) disable iff (!seq_rst_n)
    $rose(boot_go_o) |-> low_power_oscillator_ext_o == $past(slow_present))
    else $error("slow clock source choice wrong");

  // Slow clock choice frozen once booted
  a_slow_frozen: assert property (@(posedge ref_clk_i) disable iff (!seq_rst_n)
    boot_go_o |=> $stable(low_power_oscillator_ext_o))
    else $error("slow clock source changed after boot");

endmodule

// file: ssq_pkg.sv
/*
  Constants, timing counts and state type of the startup reset sequencer.
  Assumes a single 40 MHz reference clock; all counts are derived from it.
*/
package ssq_pkg;

  // Clock rate in MHz, so that times in us convert exactly
  localparam int unsigned CLK_MHZ        = 40;

  // Documented times in their own units
  localparam int unsigned POR_TYP_MS     = 3;
  localparam int unsigned POR_MIN_US     = 1500;
  localparam int unsigned CLKREQ_DLY_US  = 120;
  localparam int unsigned SLEEP_MIN_US   = 4200;

  // Derived cycle counts (exact multiples, no rounding needed)
  localparam int unsigned POR_TYP_CYC    = POR_TYP_MS * 1000 * CLK_MHZ;
  localparam int unsigned POR_MIN_CYC    = POR_MIN_US * CLK_MHZ;
  localparam int unsigned CLKREQ_CYC     = CLKREQ_DLY_US * CLK_MHZ;
  localparam int unsigned SLEEP_MIN_CYC  = SLEEP_MIN_US * CLK_MHZ;

  // Counter widths
  localparam int unsigned CNT_W          = 18;
  localparam int unsigned WIN_W          = 12;

  // Slow clock activity detector: one window spans 2**WIN_W cycles
  localparam logic [WIN_W-1:0] WIN_LAST  = 12'hFFF;
  localparam logic [1:0]       MIN_EDGES = 2'h2;

  // Values after reset
  localparam logic CLK_REQ_RST           = 1'b0;
  localparam logic DONE_RST              = 1'b0;
  localparam logic REF_MOD_SEL_RST       = 1'b0;
  localparam logic SLOW_EXT_SEL_RST      = 1'b0;
  localparam logic [CNT_W-1:0] CNT_RST   = 18'h00000;

  typedef enum logic [0:0] {
    SEQ_SLEEP,
    SEQ_RUN
  } ssq_state_e;

endpackage

// file: ssq_rst_sync.sv
/*
  Reset synchroniser: asserts asynchronously, releases on the second clock edge.
  Assumes the async reset input is glitch free (gates of flops and a pin).
*/
`timescale 1ns/1ps
module ssq_rst_sync
(
  // Clock and async reset
  input  wire logic ref_clk_i,
  input  wire logic arst_n_i,
  // Synchronised reset
  output logic      rst_n_o
);
  import ssq_pkg::*;

  logic stage_q;
  logic stage_d;
  logic out_q;
  logic out_d;

  always_comb
  begin
    stage_d = 1'b1;
    out_d   = stage_q;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      stage_q <= 1'b0;
      out_q   <= 1'b0;
    end
    else
    begin
      stage_q <= stage_d;
      out_q   <= out_d;
    end
  end

  assign rst_n_o = out_q;

endmodule

// file: ssq_slow_det.sv
/*
  Slow clock activity detector: counts edges of the slow clock input
  within fixed windows and reports whether it is toggling.
  Assumes the slow clock input is already synchronous to ref_clk_i.
*/
`timescale 1ns/1ps
module ssq_slow_det
(
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // Slow clock input
  input  wire logic slow_clock_input_i,
  // Result of last complete window
  output logic      present_o
);
  import ssq_pkg::*;

  logic             prev_q;
  logic             prev_d;
  logic [WIN_W-1:0] win_q;
  logic [WIN_W-1:0] win_d;
  logic [1:0]       edges_q;
  logic [1:0]       edges_d;
  logic             present_q;
  logic             present_d;
  logic             edge_seen;

  // edge count per window decides presence
  always_comb
  begin
    prev_d    = slow_clock_input_i;
    edge_seen = slow_clock_input_i != prev_q;
    win_d     = win_q + 12'h001;
    edges_d   = edges_q;
    present_d = present_q;
    if (edge_seen && edges_q != 2'h3)
    begin
      edges_d = edges_q + 2'h1;
    end
    if (win_q == WIN_LAST)
    begin
      present_d = edges_d >= MIN_EDGES;
      edges_d   = 2'h0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prev_q    <= 1'b0;
      win_q     <= 12'h000;
      edges_q   <= 2'h0;
      present_q <= 1'b0;
    end
    else
    begin
      prev_q    <= prev_d;
      win_q     <= win_d;
      edges_q   <= edges_d;
      present_q <= present_d;
    end
  end

  assign present_o = present_q;

  // A stuck input never reports a present clock
  a_stuck_absent: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (win_q == WIN_LAST && edges_q == 2'h0 && !edge_seen) |=> !present_o)
    else $error("slow clock reported present without edges");

endmodule

// file: ssq_host_model.sv
/*
  Host side model: drives the external reset pin, the reference strap and
  the slow clock. Assumes the bench sets its controls after a clock edge.
*/
`timescale 1ns/1ps
module ssq_host_model
#(
  parameter int unsigned HALF_CYC = 16
)
(
  // Clock
  input  wire logic ref_clk_i,
  // Controls from the bench
  input  wire logic hold_rst_i,
  input  wire logic module_fit_i,
  input  wire logic slow_on_i,
  // Pins towards the device
  output logic      ext_rst_n_o,
  output logic      strap_o,
  output logic      slow_o
);
  int unsigned cnt   = 0;
  logic        lvl_q = 1'b0;

  assign ext_rst_n_o = ~hold_rst_i;
  assign strap_o = module_fit_i;
  assign slow_o  = lvl_q;

  // slow clock runs early
  // Absent clock stands still, so the detector sees no edges at all
  always @(posedge ref_clk_i)
  begin
    if (!slow_on_i)
    begin
      cnt   <= 0;
      lvl_q <= 1'b0;
    end
    else if (cnt == HALF_CYC - 1)
    begin
      cnt   <= 0;
      lvl_q <= ~lvl_q;
    end
    else
      cnt <= cnt + 1;
  end
endmodule

// file: startup_reset_sequencer_test.sv
/*
  Self-checking bench of the startup reset sequencer with shortened counts.
  Assumes the host model supplies the pin, the strap and the slow clock.
*/
`timescale 1ns/1ps
module startup_reset_sequencer_test;
  import ssq_pkg::*;

  // Short counts keep the run brief
  localparam int POR = 20;
  localparam int CRQ = 5;
  localparam int SLP = 9000;

  logic ref_clk_i = 1'b0;
  logic nrst_i    = 1'b0;
  logic hold_c    = 1'b0;
  logic fit_c     = 1'b0;
  logic slow_c    = 1'b0;
  logic ext_rst_n, strap, slow_clk;
  logic por_active_o, chip_rst_n_o, clk_req_o, sleep_o, boot_go_o;
  logic crystal_osc_en_o, ref_from_module_o, low_power_oscillator_ext_o;
  int   error_cnt = 0;
  int   tests_run = 0;

  always #12.5 ref_clk_i = ~ref_clk_i;

  ssq_host_model host
  (
    .ref_clk_i  (ref_clk_i),
    .hold_rst_i (hold_c),
    .module_fit_i(fit_c),
    .slow_on_i  (slow_c),
    .ext_rst_n_o(ext_rst_n),
    .strap_o    (strap),
    .slow_o     (slow_clk)
  );

  ssq_startup_seq #(.POR_CYCLES(POR), .CLKREQ_CYCLES(CRQ), .SLEEP_CYCLES(SLP)) dut
  (
    .ref_clk_i                 (ref_clk_i),
    .nrst_i                    (nrst_i),
    .ext_rst_n_i               (ext_rst_n),
    .temp_comp_ref_oscillator_i(strap),
    .slow_clock_input_i        (slow_clk),
    .por_active_o              (por_active_o),
    .chip_rst_n_o              (chip_rst_n_o),
    .clk_req_o                 (clk_req_o),
    .sleep_o                   (sleep_o),
    .boot_go_o                 (boot_go_o),
    .crystal_osc_en_o          (crystal_osc_en_o),
    .ref_from_module_o         (ref_from_module_o),
    .low_power_oscillator_ext_o(low_power_oscillator_ext_o)
  );

  task summarize;
    if (error_cnt == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input bit ok, input string msg);
    tests_run++;
    if (!ok)
    begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  // Drive and sample at one fixed offset after the edge
  task step;
    @(posedge ref_clk_i);
    #2;
  endtask

  function logic pick(input int k);
    case (k)
      0:       return chip_rst_n_o;
      1:       return clk_req_o;
      2:       return boot_go_o;
      default: return ~por_active_o;
    endcase
  endfunction

  function logic exp_xtal(input logic fitted);
    return ~fitted;
  endfunction

  task count_to(input int k, input int lim, output int n);
    n = 0;
    while (pick(k) !== 1'b1 && n < lim)
    begin
      step;
      n++;
    end
  endtask

  task run(input bit ext_path, input logic fit, input logic slow);
    int n;
    nrst_i = 1'b0;
    hold_c = ext_path;
    fit_c  = fit;
    slow_c = slow;
    step;
    step;
    chk(chip_rst_n_o === 1'b0 && por_active_o === 1'b1, "out of reset too early");
    nrst_i = 1'b1;
    if (ext_path)
    begin
      repeat (POR + 10) step;
      chk(chip_rst_n_o === 1'b0 && sleep_o === 1'b0, "started while pin held");
      chk(por_active_o === 1'b0, "power-on timer still running");
      hold_c = 1'b0;
      count_to(0, 10, n);
      chk(n == 2, "release not set by pin");
    end
    else
    begin
      count_to(3, POR + 5, n);
      chk(n == POR, "power-on time wrong");
      count_to(0, 10, n);
      chk(n == 2, "release not on clock edge");
    end
    chk(sleep_o === 1'b1 && boot_go_o === 1'b0 && clk_req_o === 1'b0, "not asleep");
    count_to(1, CRQ + 5, n);
    chk(n == CRQ, "clock request delay wrong");
    chk(ref_from_module_o === fit && crystal_osc_en_o === exp_xtal(fit), "reference");
    count_to(2, SLP, n);
    chk(n == SLP - CRQ, "sleep length wrong");
    chk(sleep_o === 1'b0 && clk_req_o === 1'b1, "sleep end state");
    chk(low_power_oscillator_ext_o === slow, "slow clock choice wrong");
    // Abort while running: pin must act without waiting for a clock
    hold_c = 1'b1;
    #1;
    chk(chip_rst_n_o === 1'b0, "pin reset not immediate");
    step;
    chk(clk_req_o === 1'b0 && boot_go_o === 1'b0, "sequence not cleared");
  endtask

  // Supply drop in mid-sleep restarts the power-on timer at once
  task supply_drop;
    nrst_i = 1'b1;
    hold_c = 1'b0;
    repeat (CRQ + 4) step;
    chk(sleep_o === 1'b1 && clk_req_o === 1'b1, "not asleep before drop");
    nrst_i = 1'b0;
    #1;
    chk(chip_rst_n_o === 1'b0 && por_active_o === 1'b1, "supply drop not immediate");
    chk(clk_req_o === 1'b0 && sleep_o === 1'b0, "sequence kept after drop");
  endtask

  initial
  begin
    void'($urandom(32'h8347EB42));
    run(1'b0, 1'b1, 1'b1);
    run(1'b1, 1'b0, 1'b0);
    repeat (2) run(1'($urandom % 2), 1'($urandom % 2), 1'($urandom % 2));
    supply_drop;
    summarize;
  end

  // Four runs of about 9030 cycles each and a short drop test
  initial
  begin
    repeat (60000) @(posedge ref_clk_i);
    error_cnt++;
    summarize;
  end
endmodule
